// ### design/stmx_defs.svh
// Offsets, field positions, reset values and sizes of the sidetone mixer
`ifndef STMX_DEFS_SVH
`define STMX_DEFS_SVH

// Register indices; the byte address is four times the index
`define STMX_IDX_POWER_MGMT_FOUR   8'h0B
`define STMX_IDX_PLAYBACK_VOL_L    8'h32
`define STMX_IDX_PLAYBACK_VOL_R    8'h33
`define STMX_IDX_SIDETONE_ROUTE    8'h3C
`define STMX_IDX_SIDETONE_GAIN_DIV 8'h44

// Field positions
`define STMX_PM_LEFT_EN_BIT        4
`define STMX_PM_RIGHT_EN_BIT       5
`define STMX_VOL_EN_BIT            15
`define STMX_GAIN_LEFT_MSB         11
`define STMX_GAIN_LEFT_LSB         8
`define STMX_GAIN_RIGHT_MSB        7
`define STMX_GAIN_RIGHT_LSB        4
`define STMX_SEL_LEFT_MSB          13
`define STMX_SEL_LEFT_LSB          12
`define STMX_SEL_RIGHT_MSB         11
`define STMX_SEL_RIGHT_LSB         10

// Reset values
`define STMX_RST_POWER_MGMT        16'h0000
`define STMX_RST_PLAYBACK_VOL      15'h00C0
`define STMX_RST_ROUTE             16'h0000
`define STMX_RST_GAIN_DIV          16'h0000

// Data path sizes
`define STMX_SAMPLE_W              24
`define STMX_FIFO_DEPTH            32
`define STMX_COEF_FRAC             15

`endif

// ### design/stmx_pkg.sv
// Types shared by the sidetone mixer
package stmx_pkg;

  // One stereo sample pair
  typedef struct packed {
    logic signed [23:0] left;
    logic signed [23:0] right;
  } stmx_stereo_type;

  // Sidetone source selector coding
  typedef enum logic [1:0] {
    STMX_SEL_NONE   = 2'b00,
    STMX_SEL_LEFT   = 2'b01,
    STMX_SEL_RIGHT  = 2'b10,
    STMX_SEL_UNUSED = 2'b11
  } stmx_sel_type;

endpackage

// ### design/stmx_sidetone_mixer.sv
// Sidetone mixer with playback FIFO, converter enables and Wishbone registers
//
// Notes on behaviour
// - Sidetone added only when sample rates match
// - Selected record sample added per playback channel
// - Record samples taken after the high-pass filter
// - Left gain bits 11:8, -36dB, 3dB steps
// - Right gain bits 7:4, same coding
// - Gain codes 1100 to 1111 give 0dB
// - Left selector bits 13:12: none, left, right
// - Right selector bits 11:10, same coding
// - Both selectors reset to no sidetone
// - Enables at bits 4,5 and bit 15
// - Aliased enable locations share one bit
// - Playback accepts rates 8kHz to 48kHz
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`include "stmx_defs.svh"

// Synchronous FIFO with registered ready and valid flags
module stmx_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 32
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];   // Storage words
  logic [AW-1:0]    wr_ptr_q;      // Write position
  logic [AW-1:0]    rd_ptr_q;      // Read position
  logic [AW:0]      count_q;       // Words held
  logic [AW:0]      count_d;       // Next word count
  logic             push;          // Word accepted
  logic             pop;           // Word delivered

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_q];

  // Occupancy after this cycle
  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  // Storage write; no reset needed on data
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // Pointers and flags; flags registered so they never glitch
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_ptr_q  <= '0;
      rd_ptr_q  <= '0;
      count_q   <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      count_q   <= count_d;
      in_ready  <= (count_d != DEPTH[AW:0]);
      out_valid <= (count_d != '0);
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end
endmodule // stmx_fifo

// Top level: mixes sidetone into the playback stream
module stmx_sidetone_mixer (
  input  wire logic                     mclk,
  input  wire logic                     sys_rst,
  // Wishbone classic slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [9:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // Record and playback share one sample rate
  input  wire logic                     rates_match,
  // High-pass filtered record samples
  input  wire stmx_pkg::stmx_stereo_type record_sample,
  input  wire logic                     record_valid,
  // Playback samples from the audio interface
  input  wire stmx_pkg::stmx_stereo_type playback_sample,
  input  wire logic                     playback_valid,
  output logic                          playback_ready,
  // Mixed samples toward the interpolation path
  output stmx_pkg::stmx_stereo_type     mixed_sample,
  output logic                          mixed_valid,
  input  wire logic                     mixed_ready,
  // Converter enables
  output logic                          left_playback_converter_enable,
  output logic                          right_playback_converter_enable
);
  localparam int SW = `STMX_SAMPLE_W;

  // Register storage; enables live outside the words they alias into
  logic [15:0]  power_mgmt_q;                 // Other power bits
  logic [14:0]  vol_left_q;                   // Left volume word bits 14:0
  logic [14:0]  vol_right_q;                  // Right volume word bits 14:0
  logic [15:0]  route_q;                      // Sidetone route word
  logic [15:0]  gain_div_q;                   // Sidetone gain word
  logic         en_left_q;                    // Single left enable bit
  logic         en_right_q;                   // Single right enable bit

  logic         bus_req;                      // New bus access this cycle
  logic         bus_wr;                       // Acknowledged write this cycle
  logic [7:0]   bus_idx;                      // Register index
  logic [15:0]  rd_word;                      // Read mux result

  stmx_pkg::stmx_stereo_type rec_q;           // Latest record pair
  stmx_pkg::stmx_stereo_type fifo_data;       // FIFO head
  logic         fifo_valid;                   // FIFO head valid
  logic         fifo_ready;                   // Output stage can take
  logic         fifo_in_ready;                // FIFO has room
  logic signed [SW+1:0] scaled_left;          // Scaled left record
  logic signed [SW+1:0] scaled_right;         // Scaled right record

  // Merge byte lanes 0 and 1 into a 16-bit word
  function automatic logic [15:0] lane_merge(input logic [15:0] old_w,
                                             input logic [15:0] new_w,
                                             input logic [1:0]  sel);
    logic [15:0] r;
    r = old_w;
    if (sel[0]) begin
      r[7:0] = new_w[7:0];
    end
    if (sel[1]) begin
      r[15:8] = new_w[15:8];
    end
    return r;
  endfunction

  // Gain coefficient, 0dB equals 2^15
  function automatic logic [16:0] gain_coef(input logic [3:0] code);
    logic [16:0] c;
    case (code)
      4'h0:    c = 17'h00207;               // -36dB
      4'h1:    c = 17'h002DE;               // -33dB
      4'h2:    c = 17'h0040C;               // -30dB
      4'h3:    c = 17'h005B8;               // -27dB
      4'h4:    c = 17'h00813;               // -24dB
      4'h5:    c = 17'h00B68;               // -21dB
      4'h6:    c = 17'h0101D;               // -18dB
      4'h7:    c = 17'h016C3;               // -15dB
      4'h8:    c = 17'h02027;               // -12dB
      4'h9:    c = 17'h02D6B;               // -9dB
      4'hA:    c = 17'h04027;               // -6dB
      4'hB:    c = 17'h05A9E;               // -3dB
      default: c = 17'h08000;               // 0dB for 1100 and above
    endcase
    return c;
  endfunction

  // Scale one record sample; never above unity so 26 bits hold it
  function automatic logic signed [SW+1:0] scale(input logic signed [SW-1:0] s,
                                                 input logic [3:0] code);
    logic signed [41:0] p;
    p = s * $signed({1'b0, gain_coef(code)});
    return p[`STMX_COEF_FRAC+SW+1:`STMX_COEF_FRAC];
  endfunction

  // Add sidetone to one playback sample with saturation
  function automatic logic signed [SW-1:0] mix(input logic signed [SW-1:0] play,
                                               input logic [1:0] sel,
                                               input logic signed [SW+1:0] sl,
                                               input logic signed [SW+1:0] sr,
                                               input logic active);
    logic signed [SW+2:0] side;
    logic signed [SW+2:0] sum;
    logic signed [SW-1:0] r;
    side = '0;
    if (active) begin
      case (stmx_pkg::stmx_sel_type'(sel))
        stmx_pkg::STMX_SEL_LEFT:  side = {sl[SW+1], sl};
        stmx_pkg::STMX_SEL_RIGHT: side = {sr[SW+1], sr};
        default:                  side = '0;
      endcase
    end
    sum = {{3{play[SW-1]}}, play} + side;
    if (sum > $signed({3'b000, 1'b0, {(SW-1){1'b1}}})) begin
      r = {1'b0, {(SW-1){1'b1}}};
    end else if (sum < $signed({3'b111, 1'b1, {(SW-1){1'b0}}})) begin
      r = {1'b1, {(SW-1){1'b0}}};
    end else begin
      r = sum[SW-1:0];
    end
    return r;
  endfunction

  assign bus_idx = wb_adr_i[9:2];
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes land at the edge where the master sees ack high, never earlier
  assign bus_wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  // Read mux; unmapped indices read zero
  always_comb begin
    rd_word = 16'h0000;
    case (bus_idx)
      `STMX_IDX_POWER_MGMT_FOUR: begin
        rd_word = power_mgmt_q;
        rd_word[`STMX_PM_LEFT_EN_BIT]  = en_left_q;
        rd_word[`STMX_PM_RIGHT_EN_BIT] = en_right_q;
      end
      `STMX_IDX_PLAYBACK_VOL_L:    rd_word = {en_left_q, vol_left_q};
      `STMX_IDX_PLAYBACK_VOL_R:    rd_word = {en_right_q, vol_right_q};
      `STMX_IDX_SIDETONE_ROUTE:    rd_word = route_q;
      `STMX_IDX_SIDETONE_GAIN_DIV: rd_word = gain_div_q;
      default:                     rd_word = 16'h0000;
    endcase
  end

  // Bus answer: ack one cycle after the strobe, dropped the next
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req) begin
        wb_dat_o <= {16'h0000, rd_word};
      end
    end
  end

  // Plain register words
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      power_mgmt_q <= `STMX_RST_POWER_MGMT;
      vol_left_q   <= `STMX_RST_PLAYBACK_VOL;
      vol_right_q  <= `STMX_RST_PLAYBACK_VOL;
      route_q      <= `STMX_RST_ROUTE;
      gain_div_q   <= `STMX_RST_GAIN_DIV;
    end else if (bus_wr) begin
      case (bus_idx)
        `STMX_IDX_POWER_MGMT_FOUR:
          power_mgmt_q <= lane_merge(power_mgmt_q, wb_dat_i[15:0], wb_sel_i[1:0]);
        `STMX_IDX_PLAYBACK_VOL_L:
          vol_left_q <= 15'(lane_merge({1'b0, vol_left_q}, wb_dat_i[15:0], wb_sel_i[1:0]));
        `STMX_IDX_PLAYBACK_VOL_R:
          vol_right_q <= 15'(lane_merge({1'b0, vol_right_q}, wb_dat_i[15:0], wb_sel_i[1:0]));
        `STMX_IDX_SIDETONE_ROUTE:
          route_q <= lane_merge(route_q, wb_dat_i[15:0], wb_sel_i[1:0]);
        `STMX_IDX_SIDETONE_GAIN_DIV:
          gain_div_q <= lane_merge(gain_div_q, wb_dat_i[15:0], wb_sel_i[1:0]);
        default: begin
          // Unmapped writes are dropped
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      en_left_q  <= 1'b0;
      en_right_q <= 1'b0;
    end else if (bus_wr) begin
      if (bus_idx == `STMX_IDX_POWER_MGMT_FOUR && wb_sel_i[0]) begin
        en_left_q  <= wb_dat_i[`STMX_PM_LEFT_EN_BIT];
        en_right_q <= wb_dat_i[`STMX_PM_RIGHT_EN_BIT];
      end
      if (bus_idx == `STMX_IDX_PLAYBACK_VOL_L && wb_sel_i[1]) begin
        en_left_q <= wb_dat_i[`STMX_VOL_EN_BIT];
      end
      if (bus_idx == `STMX_IDX_PLAYBACK_VOL_R && wb_sel_i[1]) begin
        en_right_q <= wb_dat_i[`STMX_VOL_EN_BIT];
      end
    end
  end

  // Enables leave straight from their storage flops
  assign left_playback_converter_enable  = en_left_q;
  assign right_playback_converter_enable = en_right_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rec_q <= '0;
    end else if (record_valid) begin
      rec_q <= record_sample;
    end
  end

  stmx_fifo #(
    .WIDTH (2 * SW),
    .DEPTH (`STMX_FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_data   (playback_sample),
    .in_valid  (playback_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready)
  );

  // FIFO ready is itself a flop, so the port stays registered
  assign playback_ready = fifo_in_ready;

  assign scaled_left  = scale(rec_q.left,
                              gain_div_q[`STMX_GAIN_LEFT_MSB:`STMX_GAIN_LEFT_LSB]);
  assign scaled_right = scale(rec_q.right,
                              gain_div_q[`STMX_GAIN_RIGHT_MSB:`STMX_GAIN_RIGHT_LSB]);

  // Output stage drains the FIFO whenever it is empty or emptying
  assign fifo_ready = !mixed_valid || mixed_ready;

  // Mixed output register; stalls hold the sample and back up the FIFO
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mixed_valid  <= 1'b0;
      mixed_sample <= '0;
    end else if (fifo_ready) begin
      mixed_valid <= fifo_valid;
      if (fifo_valid) begin
        mixed_sample.left  <= mix(fifo_data.left,
                                  route_q[`STMX_SEL_LEFT_MSB:`STMX_SEL_LEFT_LSB],
                                  scaled_left, scaled_right, rates_match);
        mixed_sample.right <= mix(fifo_data.right,
                                  route_q[`STMX_SEL_RIGHT_MSB:`STMX_SEL_RIGHT_LSB],
                                  scaled_left, scaled_right, rates_match);
      end
    end
  end
endmodule // stmx_sidetone_mixer

// ### tb/stmx_sidetone_mixer_checker.sv
// Port-level assertions for the sidetone mixer
`timescale 1ns/1ps
module stmx_sidetone_mixer_checker (
  input wire logic                      mclk,
  input wire logic                      sys_rst,
  input wire logic                      wb_cyc_i,
  input wire logic                      wb_stb_i,
  input wire logic                      wb_we_i,
  input wire logic [9:0]                wb_adr_i,
  input wire logic [3:0]                wb_sel_i,
  input wire logic [31:0]               wb_dat_i,
  input wire logic [31:0]               wb_dat_o,
  input wire logic                      wb_ack_o,
  input wire logic                      playback_ready,
  input wire stmx_pkg::stmx_stereo_type mixed_sample,
  input wire logic                      mixed_valid,
  input wire logic                      mixed_ready,
  input wire logic                      left_playback_converter_enable,
  input wire logic                      right_playback_converter_enable
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Short names for the enables and for an answered access
  wire logic       en_l = left_playback_converter_enable;
  wire logic       en_r = right_playback_converter_enable;
  wire logic [7:0] idx  = wb_adr_i[9:2];
  wire logic       acc  = wb_cyc_i & wb_stb_i & wb_ack_o;

  // Answer comes one cycle after a new request
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  // Answer is a single-cycle pulse
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  // Outputs idle straight after reset
  property p_rst_idle;
    $fell(sys_rst) |-> !wb_ack_o && !mixed_valid && !playback_ready && !en_l && !en_r;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
  // Power register write sets both enables
  property p_pm_wr;
    acc && wb_we_i && idx == 8'h0B && wb_sel_i[0] |=>
      en_l == $past(wb_dat_i[4]) && en_r == $past(wb_dat_i[5]);
  endproperty
  a_pm_wr: assert property (p_pm_wr) else $error("power write lost");
  // Left volume bit 15 writes the same enable
  property p_vol_wr;
    acc && wb_we_i && idx == 8'h32 && wb_sel_i[1] |=> en_l == $past(wb_dat_i[15]);
  endproperty
  a_vol_wr: assert property (p_vol_wr) else $error("alias write lost");
  // Left volume bit 15 reads the enable
  property p_vol_rd;
    acc && !wb_we_i && idx == 8'h32 |-> wb_dat_o[15] == en_l;
  endproperty
  a_vol_rd: assert property (p_vol_rd) else $error("alias read wrong");
  // Power register reads both enables
  property p_pm_rd;
    acc && !wb_we_i && idx == 8'h0B |-> wb_dat_o[5:4] == {en_r, en_l};
  endproperty
  a_pm_rd: assert property (p_pm_rd) else $error("power read wrong");
  // A stalled output pair is held unchanged
  property p_out_hold;
    mixed_valid && !mixed_ready |=> mixed_valid && $stable(mixed_sample);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output dropped");

  c_pm_wr: cover property (acc && wb_we_i && idx == 8'h0B);
  c_mix: cover property (mixed_valid && mixed_ready);
  c_full: cover property (!playback_ready && !mixed_ready);
endmodule // stmx_sidetone_mixer_checker

bind stmx_sidetone_mixer stmx_sidetone_mixer_checker i_stmx_sidetone_mixer_checker (
  .mclk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .playback_ready, .mixed_sample, .mixed_valid, .mixed_ready,
  .left_playback_converter_enable, .right_playback_converter_enable);

// ### tb/stmx_partner.sv
// Model of the record filter and audio interface feeding the mixer
`timescale 1ns/1ps
module stmx_partner (
  input  wire logic                mclk,
  input  wire logic                playback_ready,
  output stmx_pkg::stmx_stereo_type record_sample,
  output logic                     record_valid,
  output stmx_pkg::stmx_stereo_type playback_sample,
  output logic                     playback_valid
);
  // Idle at time zero
  initial begin
    record_sample   = '0;
    record_valid    = 1'b0;
    playback_sample = '0;
    playback_valid  = 1'b0;
  end

  task automatic rec(input stmx_pkg::stmx_stereo_type s);
    @(posedge mclk);
    record_sample <= s;
    record_valid  <= 1'b1;
    @(posedge mclk);
    record_valid  <= 1'b0;
    // Stale data inverted so nothing leans on it
    record_sample <= ~s;
  endtask

  task automatic play(input stmx_pkg::stmx_stereo_type s);
    @(posedge mclk);
    playback_sample <= s;
    playback_valid  <= 1'b1;
    do @(posedge mclk); while (playback_ready !== 1'b1);
    playback_valid  <= 1'b0;
    playback_sample <= ~s;
  endtask
endmodule // stmx_partner

// ### tb/stmx_sidetone_mixer_tb_top.sv
// Self-checking bench for the sidetone mixer
`timescale 1ns/1ps
module stmx_sidetone_mixer_tb_top;
  // Design pins
  logic                      mclk     = 1'b0;
  logic                      sys_rst  = 1'b1;
  logic                      wb_cyc_i = 1'b0;
  logic                      wb_stb_i = 1'b0;
  logic                      wb_we_i  = 1'b0;
  logic [9:0]                wb_adr_i = 10'h000;
  logic [3:0]                wb_sel_i = 4'h0;
  logic [31:0]               wb_dat_i = 32'h00000000;
  logic [31:0]               wb_dat_o;
  logic                      wb_ack_o, playback_ready, mixed_valid, rec_v, pb_v, en_l, en_r;
  logic                      rates_match = 1'b1;
  logic                      mixed_ready = 1'b1;
  stmx_pkg::stmx_stereo_type rec_s, pb_s, mixed_sample, got;
  int                        miscompares = 0;
  int                        n_tests     = 0;
  int                        cycles      = 0;
  // One ordinary case: settings, pairs in, pair expected
  typedef struct {
    logic [15:0]               route;
    logic [15:0]               gain;
    logic                      rm;
    stmx_pkg::stmx_stereo_type rec, pb, want;
  } stmx_row_type;
  stmx_row_type rows [9] = '{
    '{16'h0000, 16'h0CC0, 1'b1, '{24'h000100, 24'h000200}, '{24'h000010, 24'h000020},
      '{24'h000010, 24'h000020}},
    '{16'h1800, 16'h0CF0, 1'b1, '{24'h000100, 24'h000200}, '{24'h000010, 24'h000020},
      '{24'h000110, 24'h000220}},
    '{16'h2400, 16'h0DE0, 1'b1, '{24'h000100, 24'h000200}, '{24'h000010, 24'h000020},
      '{24'h000210, 24'h000120}},
    '{16'h3C00, 16'h0CC0, 1'b1, '{24'h000100, 24'h000200}, '{24'h000010, 24'h000020},
      '{24'h000010, 24'h000020}},
    '{16'h1400, 16'h00C0, 1'b1, '{24'h008000, 24'h000000}, '{24'h000000, 24'h000000},
      '{24'h000207, 24'h000207}},
    '{16'h2800, 16'h0C00, 1'b1, '{24'h000000, 24'h008000}, '{24'h000000, 24'h000000},
      '{24'h000207, 24'h000207}},
    '{16'h1800, 16'h0CC0, 1'b0, '{24'h000100, 24'h000200}, '{24'h000010, 24'h000020},
      '{24'h000010, 24'h000020}},
    '{16'h1800, 16'h0CC0, 1'b1, '{24'h000100, 24'hFFFF00}, '{24'h7FFFF0, 24'h800010},
      '{24'h7FFFFF, 24'h800000}},
    '{16'h3000, 16'h0CC0, 1'b1, '{24'h000100, 24'h000200}, '{24'h000010, 24'h000020},
      '{24'h000010, 24'h000020}}
  };

  stmx_sidetone_mixer i_stmx_sidetone_mixer (
    .mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rates_match(rates_match),
    .record_sample(rec_s), .record_valid(rec_v), .playback_sample(pb_s),
    .playback_valid(pb_v), .playback_ready(playback_ready), .mixed_sample(mixed_sample),
    .mixed_valid(mixed_valid), .mixed_ready(mixed_ready),
    .left_playback_converter_enable(en_l), .right_playback_converter_enable(en_r));
  stmx_partner i_stmx_partner (
    .mclk(mclk), .playback_ready(playback_ready), .record_sample(rec_s),
    .record_valid(rec_v), .playback_sample(pb_s), .playback_valid(pb_v));

  // 250 MHz clock
  always #2 mclk = ~mclk;

  // Hang guard, well above the expected run
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      miscompares++;
      stop_test();
    end
  end

  // Compare and count
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] want);
    n_tests++;
    if (seen !== want) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, want, seen);
    end
  endtask

  // One classic Wishbone cycle; waits for the answer
  task automatic bus(input logic we, input logic [7:0] idx, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0000, d};
    do @(posedge mclk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, idx, d, q);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [15:0] want);
    logic [15:0] q;
    bus(1'b0, idx, 16'h0000, q);
    check("register", 48'(q), 48'(want));
  endtask

  // Next output pair, bounded wait; ready is held high by the caller
  task automatic get_mix(output stmx_pkg::stmx_stereo_type s);
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (mixed_valid !== 1'b1 && k < 50);
    // A missing pair reads unknown, so the compare counts it
    if (mixed_valid === 1'b1) begin
      s = mixed_sample;
    end else begin
      s = 'x;
    end
  endtask

  // Counts, verdict, end of run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(8'h0B, 16'h0000);
    rd(8'h32, 16'h00C0);
    rd(8'h33, 16'h00C0);
    rd(8'h3C, 16'h0000);
    rd(8'h44, 16'h0000);
    rd(8'hFF, 16'h0000);
    $display("test reset values done");
    wr(8'h0B, 16'h0030);
    rd(8'h32, 16'h80C0);
    rd(8'h33, 16'h80C0);
    check("enables", 48'({en_l, en_r}), 48'h000000000003);
    wr(8'h32, 16'h00C0);
    rd(8'h0B, 16'h0020);
    $display("test enable aliases done");
    foreach (rows[i]) begin
      wr(8'h3C, rows[i].route);
      wr(8'h44, rows[i].gain);
      rates_match <= rows[i].rm;
      i_stmx_partner.rec(rows[i].rec);
      i_stmx_partner.play(rows[i].pb);
      get_mix(got);
      check("mix", got, rows[i].want);
      $display("test row %0d done", i);
    end
    // Fill the buffer with the output stalled, then drain in order
    wr(8'h3C, 16'h0000);
    mixed_ready <= 1'b0;
    for (int i = 0; i < 33; i++) i_stmx_partner.play({24'(i), 24'(i)});
    repeat (2) @(posedge mclk);
    check("refused", 48'(playback_ready), 48'h000000000000);
    mixed_ready <= 1'b1;
    for (int i = 0; i < 33; i++) begin
      get_mix(got);
      check("order", got, {24'(i), 24'(i)});
    end
    repeat (3) @(posedge mclk);
    check("drained", 48'(mixed_valid), 48'h000000000000);
    $display("test buffer done");
    // Reset in mid-run must clear programmed selectors and enables
    wr(8'h3C, 16'h2400);
    wr(8'h0B, 16'h0030);
    sys_rst <= 1'b1;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(8'h3C, 16'h0000);
    rd(8'h33, 16'h00C0);
    check("enables", 48'({en_l, en_r}), 48'h000000000000);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule // stmx_sidetone_mixer_tb_top
